// File: acf_host_framer.v
// Purpose: host end of the audio channel: builds output units, parses input units
// Assumes: APB register access, word-wide link in both directions
// Notes: payload for one unit is staged in a 20-word store before sending
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "acf_consts.vh"

// Notes on behaviour
// - host audio is stereo 16-bit PCM at 32, 44.1 or 48 kHz
// - no audio unit leaves before software marks client capabilities read
// - units leave at a fixed pace from the local clock
// - one codec stream per channel; channel id frozen while streaming
// - default coding is mono DVI4
// - default stream is 8 kHz with 20 ms per unit
// - non-interleaved payload carries all left then all right samples
// - codec record starts with type 0x0001 then length 0x0004
// - codec field 8 bits: 0 PCM, 1 DVI4
// - sample size 8 bits, zero when adaptive
// - channel count and device index 8 bits; 0 left, 1 right
// - output unit: 0x00, channel id, 0x20 0x01 length, tag, seq, payload
// - extended only when extended bit set and control bit clear
// - extended unit leads with 0x04, channel id, then length word
module acf_host_framer
#(
  parameter [23:0] P_UNIT_CYCLES = `ACF_UNIT_CYCLES
)
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // units to the client
  output reg o_tx_valid,
  output reg [31:0] o_tx_data,
  output reg o_tx_last,
  input wire i_tx_ready,
  // units from the client
  input wire i_rx_valid,
  input wire [31:0] i_rx_data,
  input wire i_rx_last,
  output reg o_rx_ready,
  // microphone payload
  output wire o_mic_valid,
  output wire [31:0] o_mic_data,
  output wire o_mic_last,
  // extended channel pass-through
  output wire o_ext_valid,
  output wire [31:0] o_ext_data,
  output wire o_ext_last
);

  localparam S_IDLE = 8'h01;
  localparam S_HDR0 = 8'h02;
  localparam S_HDR1 = 8'h04;
  localparam S_TS = 8'h08;
  localparam S_SEQ = 8'h10;
  localparam S_PAY = 8'h20;
  localparam S_PRM0 = 8'h40;
  localparam S_PRM1 = 8'h80;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] state_q;
  reg go_q;
  reg prm_q;
  reg ts_en_q;
  reg caps_ok_q;
  reg auto_q;
  reg [23:0] chan_q;
  reg [31:0] codec_q;
  reg [31:0] tstag_q;
  reg [15:0] tx_seq_q;
  reg [4:0] wr_idx_q;
  reg [4:0] rd_idx_q;
  reg done_q;
  reg [3:0] stat_q;
  reg [23:0] tick_cnt_q;
  reg [31:0] pay_q [0:`ACF_PAY_WORDS-1];
  reg [31:0] rdata;
  reg rd_hit;

  wire rx_unit_ok;
  wire rx_gap;
  wire rx_discard;
  wire rx_ext_seen;
  wire [15:0] rx_last_seq;
  wire [15:0] rx_lost;
  wire [23:0] rx_vc;

  wire busy = (state_q != S_IDLE) | done_q;
  wire tx_free = ~o_tx_valid | i_tx_ready;
  wire can_start = tx_free & (state_q == S_IDLE) & caps_ok_q & ~done_q;
  wire take_prm = can_start & prm_q;
  wire take_go = can_start & ~prm_q & go_q;
  wire acc = i_psel & i_penable & o_pready;
  wire wr = acc & i_pwrite;
  wire tick = auto_q & (tick_cnt_q == P_UNIT_CYCLES - 24'h000001);
  wire [5:0] len_words = {1'b0, wr_idx_q} + `ACF_HDR_WORDS + {5'h00, ts_en_q};
  wire [15:0] unit_len = {8'h00, len_words, 2'b00};

  // ----------------------------------------
  // fixed unit pace
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      tick_cnt_q <= 24'h000000;
    else if (!auto_q || tick)
      tick_cnt_q <= 24'h000000;
    else
      tick_cnt_q <= tick_cnt_q + 24'h000001;
  end

  // ----------------------------------------
  // apb slave, answers in the second access cycle
  // ----------------------------------------
  always @*
  begin
    rd_hit = 1'b1;
    rdata = 32'h00000000;
    case (i_paddr)
      `ACF_REG_CTRL: rdata = {27'h0000000, auto_q, prm_q, caps_ok_q, ts_en_q, go_q};
      `ACF_REG_CHAN: rdata = {8'h00, chan_q};
      `ACF_REG_CODEC: rdata = codec_q;
      `ACF_REG_TSTAG: rdata = tstag_q;
      `ACF_REG_SEQ: rdata = {tx_seq_q, rx_last_seq};
      `ACF_REG_DATA: rdata = {27'h0000000, wr_idx_q};
      `ACF_REG_STAT: rdata = {27'h0000000, stat_q, busy};
      `ACF_REG_RXINFO: rdata = {rx_lost, rx_last_seq};
      `ACF_REG_RXVC: rdata = {8'h00, rx_vc};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
      o_rx_ready <= 1'b0;
      go_q <= 1'b0;
      prm_q <= 1'b0;
      ts_en_q <= 1'b0;
      caps_ok_q <= 1'b0;
      auto_q <= 1'b0;
      chan_q <= `ACF_CHAN_RST;
      codec_q <= `ACF_CODEC_RST;
      tstag_q <= 32'h00000000;
      wr_idx_q <= 5'h00;
      stat_q <= 4'h0;
    end
    else
    begin
      o_rx_ready <= 1'b1;
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~rd_hit;
      if (i_psel && i_penable && !o_pready)
        o_prdata <= i_pwrite ? 32'h00000000 : rdata;
      // pending requests: a new write wins over the take
      go_q <= (go_q & ~take_go) | tick | (wr & i_paddr == `ACF_REG_CTRL & i_pwdata[`ACF_CTRL_GO]);
      prm_q <= (prm_q & ~take_prm) | (wr & i_paddr == `ACF_REG_CTRL & i_pwdata[`ACF_CTRL_PRM]);
      if (wr && i_paddr == `ACF_REG_CTRL)
      begin
        ts_en_q <= i_pwdata[`ACF_CTRL_TS_EN];
        caps_ok_q <= i_pwdata[`ACF_CTRL_CAPS_OK];
        auto_q <= i_pwdata[`ACF_CTRL_AUTO];
      end
      if (wr && i_paddr == `ACF_REG_CHAN && !busy && !auto_q)
        chan_q <= i_pwdata[23:0];
      if (wr && i_paddr == `ACF_REG_CODEC && !busy)
        codec_q <= i_pwdata;
      if (wr && i_paddr == `ACF_REG_TSTAG && !busy)
        tstag_q <= i_pwdata;
      if (done_q)
        wr_idx_q <= 5'h00;
      else if (wr && i_paddr == `ACF_REG_DATA && !busy && wr_idx_q != `ACF_PAY_WORDS)
        wr_idx_q <= wr_idx_q + 5'h01;
      // sticky events, set wins over write-one-to-clear
      stat_q <= (stat_q & ~({4{wr & i_paddr == `ACF_REG_STAT}} & i_pwdata[4:1]))
        | {rx_ext_seen, rx_discard, rx_gap, rx_unit_ok};
    end
  end

  // payload store, left block then right block as software fills it
  always @(posedge i_clk)
  begin
    if (wr && i_paddr == `ACF_REG_DATA && !busy && wr_idx_q != `ACF_PAY_WORDS)
      pay_q[wr_idx_q] <= i_pwdata;
  end

  // ----------------------------------------
  // unit builder
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= S_IDLE;
      o_tx_valid <= 1'b0;
      o_tx_data <= 32'h00000000;
      o_tx_last <= 1'b0;
      rd_idx_q <= 5'h00;
      tx_seq_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (tx_free)
      begin
        o_tx_valid <= 1'b0;
        o_tx_last <= 1'b0;
        case (state_q)
          S_IDLE:
          begin
            if (take_prm)
            begin
              o_tx_valid <= 1'b1;
              o_tx_data <= {`ACF_PRM_TYPE, `ACF_PRM_LEN};
              state_q <= S_PRM0;
            end
            else if (take_go)
            begin
              o_tx_valid <= 1'b1;
              o_tx_data <= {`ACF_LEAD_AUDIO, chan_q};
              state_q <= S_HDR0;
            end
          end
          S_HDR0:
          begin
            o_tx_valid <= 1'b1;
            o_tx_data <= {`ACF_CMD_OUT, `ACF_CMD_SUB, unit_len};
            state_q <= S_HDR1;
          end
          S_HDR1:
          begin
            o_tx_valid <= 1'b1;
            if (ts_en_q)
            begin
              o_tx_data <= tstag_q;
              state_q <= S_TS;
            end
            else
            begin
              o_tx_data <= {tx_seq_q, rx_last_seq};
              o_tx_last <= (wr_idx_q == 5'h00);
              state_q <= S_SEQ;
            end
          end
          S_TS:
          begin
            o_tx_valid <= 1'b1;
            o_tx_data <= {tx_seq_q, rx_last_seq};
            o_tx_last <= (wr_idx_q == 5'h00);
            state_q <= S_SEQ;
          end
          S_SEQ:
          begin
            if (wr_idx_q == 5'h00)
            begin
              tx_seq_q <= tx_seq_q + 16'h0001;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
            else
            begin
              o_tx_valid <= 1'b1;
              o_tx_data <= pay_q[0];
              o_tx_last <= (wr_idx_q == 5'h01);
              rd_idx_q <= 5'h01;
              state_q <= S_PAY;
            end
          end
          S_PAY:
          begin
            if (rd_idx_q == wr_idx_q)
            begin
              tx_seq_q <= tx_seq_q + 16'h0001;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
            else
            begin
              o_tx_valid <= 1'b1;
              o_tx_data <= pay_q[rd_idx_q];
              o_tx_last <= (rd_idx_q + 5'h01 == wr_idx_q);
              rd_idx_q <= rd_idx_q + 5'h01;
            end
          end
          S_PRM0:
          begin
            o_tx_valid <= 1'b1;
            o_tx_data <= codec_q;
            o_tx_last <= 1'b1;
            state_q <= S_PRM1;
          end
          S_PRM1:
            state_q <= S_IDLE;
          default:
            state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // input parser
  // ----------------------------------------
  acf_rx_parse u_rx
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ts_en(ts_en_q),
    .i_valid(i_rx_valid),
    .i_data(i_rx_data),
    .i_last(i_rx_last),
    .o_mic_valid(o_mic_valid),
    .o_mic_data(o_mic_data),
    .o_mic_last(o_mic_last),
    .o_ext_valid(o_ext_valid),
    .o_ext_data(o_ext_data),
    .o_ext_last(o_ext_last),
    .o_unit_ok(rx_unit_ok),
    .o_gap(rx_gap),
    .o_discard(rx_discard),
    .o_ext_seen(rx_ext_seen),
    .o_last_seq(rx_last_seq),
    .o_lost(rx_lost),
    .o_vc(rx_vc)
  );

endmodule // acf_host_framer

`default_nettype wire

// File: acf_consts.vh
// Purpose: constants for the audio channel unit framer (host end)
// Assumes: 25 MHz clock, 32-bit APB register words
// Notes: unit bytes travel most significant byte first in each word
`ifndef ACF_CONSTS_VH
`define ACF_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACF_REG_CTRL 8'h00
`define ACF_REG_CHAN 8'h04
`define ACF_REG_CODEC 8'h08
`define ACF_REG_TSTAG 8'h0C
`define ACF_REG_SEQ 8'h10
`define ACF_REG_DATA 8'h14
`define ACF_REG_STAT 8'h18
`define ACF_REG_RXINFO 8'h1C
`define ACF_REG_RXVC 8'h20

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define ACF_CTRL_GO 0
`define ACF_CTRL_TS_EN 1
`define ACF_CTRL_CAPS_OK 2
`define ACF_CTRL_PRM 3
`define ACF_CTRL_AUTO 4
`define ACF_STAT_BUSY 0
`define ACF_STAT_RX_OK 1
`define ACF_STAT_GAP 2
`define ACF_STAT_DISC 3
`define ACF_STAT_EXT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACF_CODEC_RST 32'h01040100
`define ACF_CHAN_RST 24'h000000

// ----------------------------------------
// unit header codes
// ----------------------------------------
`define ACF_LEAD_AUDIO 8'h00
`define ACF_LEAD_EXT_BIT 2
`define ACF_LEAD_CTRL_BIT 3
`define ACF_CMD_OUT 8'h20
`define ACF_CMD_IN 8'h24
`define ACF_CMD_SUB 8'h01
`define ACF_PRM_TYPE 16'h0001
`define ACF_PRM_LEN 16'h0004
`define ACF_CODEC_PCM 8'h00
`define ACF_CODEC_DVI4 8'h01

// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define ACF_PAY_WORDS 20
`define ACF_HDR_WORDS 6'd3
`define ACF_UNIT_MS 20
`define ACF_CLK_KHZ 25000
`define ACF_UNIT_CYCLES (`ACF_UNIT_MS * `ACF_CLK_KHZ)

`endif

// File: acf_rx_parse.v
// Purpose: parses units arriving from the client
// Assumes: one 32-bit word per valid cycle, last marks the final word
// Notes: no back-pressure; outputs are registered
`timescale 1ns/1ns
`default_nettype none
`include "acf_consts.vh"

module acf_rx_parse
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // config
  input wire i_ts_en,
  // incoming words
  input wire i_valid,
  input wire [31:0] i_data,
  input wire i_last,
  // microphone payload
  output reg o_mic_valid,
  output reg [31:0] o_mic_data,
  output reg o_mic_last,
  // extended channel pass-through
  output reg o_ext_valid,
  output reg [31:0] o_ext_data,
  output reg o_ext_last,
  // events and state
  output reg o_unit_ok,
  output reg o_gap,
  output reg o_discard,
  output reg o_ext_seen,
  output reg [15:0] o_last_seq,
  output reg [15:0] o_lost,
  output reg [23:0] o_vc
);

  localparam S_W0 = 7'h01;
  localparam S_W1 = 7'h02;
  localparam S_TS = 7'h04;
  localparam S_SEQ = 7'h08;
  localparam S_PAY = 7'h10;
  localparam S_EXT = 7'h20;
  localparam S_DROP = 7'h40;

  reg [6:0] state_q;
  reg have_seq_q;
  wire [15:0] seq_exp = o_last_seq + 16'h0001;
  wire [7:0] lead = i_data[31:24];
  wire is_ext = lead[`ACF_LEAD_EXT_BIT] & ~lead[`ACF_LEAD_CTRL_BIT];

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= S_W0;
      have_seq_q <= 1'b0;
      o_mic_valid <= 1'b0;
      o_mic_data <= 32'h00000000;
      o_mic_last <= 1'b0;
      o_ext_valid <= 1'b0;
      o_ext_data <= 32'h00000000;
      o_ext_last <= 1'b0;
      o_unit_ok <= 1'b0;
      o_gap <= 1'b0;
      o_discard <= 1'b0;
      o_ext_seen <= 1'b0;
      o_last_seq <= 16'h0000;
      o_lost <= 16'h0000;
      o_vc <= 24'h000000;
    end
    else
    begin
      o_mic_valid <= 1'b0;
      o_mic_last <= 1'b0;
      o_ext_valid <= 1'b0;
      o_ext_last <= 1'b0;
      o_unit_ok <= 1'b0;
      o_gap <= 1'b0;
      o_discard <= 1'b0;
      o_ext_seen <= 1'b0;
      if (i_valid)
      begin
        case (state_q)
          S_W0:
          begin
            if (lead == `ACF_LEAD_AUDIO)
            begin
              o_vc <= i_data[23:0];
              state_q <= S_W1;
            end
            else if (is_ext)
            begin
              o_ext_seen <= 1'b1;
              state_q <= S_EXT;
            end
            else
            begin
              o_discard <= 1'b1;
              state_q <= S_DROP;
            end
          end
          S_W1:
          begin
            if (lead == `ACF_CMD_IN && i_data[23:16] == `ACF_CMD_SUB)
              state_q <= i_ts_en ? S_TS : S_SEQ;
            else
            begin
              o_discard <= 1'b1;
              state_q <= S_DROP;
            end
          end
          S_TS:
            state_q <= S_SEQ;
          S_SEQ:
          begin
            // gaps are counted, never asked for again
            if (have_seq_q && i_data[31:16] != seq_exp)
            begin
              o_gap <= 1'b1;
              o_lost <= o_lost + (i_data[31:16] - seq_exp);
            end
            have_seq_q <= 1'b1;
            o_last_seq <= i_data[31:16];
            o_unit_ok <= 1'b1;
            state_q <= S_PAY;
          end
          S_PAY:
          begin
            o_mic_valid <= 1'b1;
            o_mic_data <= i_data;
            o_mic_last <= i_last;
          end
          S_EXT:
          begin
            // words after the leading word are opaque
            o_ext_valid <= 1'b1;
            o_ext_data <= i_data;
            o_ext_last <= i_last;
          end
          S_DROP:
            state_q <= S_DROP;
          default:
            state_q <= S_W0;
        endcase
        if (i_last)
          state_q <= S_W0;
      end
    end
  end

endmodule // acf_rx_parse

`default_nettype wire

// File: acf_chk.sv
// Purpose: port assertions for acf_host_framer
// Assumes: one clock, async active-high reset
// Notes: bound to every framer instance
`timescale 1ns/1ns
`default_nettype none
module acf_chk
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // links
  input wire logic o_tx_valid,
  input wire logic [31:0] o_tx_data,
  input wire logic o_tx_last,
  input wire logic i_tx_ready,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic o_rx_ready,
  // user side
  input wire logic o_mic_valid,
  input wire logic [31:0] o_mic_data,
  input wire logic o_mic_last,
  input wire logic o_ext_valid,
  input wire logic [31:0] o_ext_data,
  input wire logic o_ext_last
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_apb_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_tx_stall;
    o_tx_valid && !i_tx_ready;
  endsequence
  a_apb_one_wait: assert property (s_apb_wait |=> o_pready) else $error("pready not after one wait");
  a_pready_pulse: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
  a_tx_held: assert property (s_tx_stall |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
    else $error("tx word changed while stalled");
  a_rx_ready_up: assert property (!o_rx_ready |-> $past(i_rst)) else $error("rx ready low after reset");
  a_mic_follow: assert property (o_mic_valid |-> $past(i_rx_valid) && o_mic_data == $past(i_rx_data)
    && o_mic_last == $past(i_rx_last)) else $error("mic word not the input word");
  a_ext_follow: assert property (o_ext_valid |-> $past(i_rx_valid) && o_ext_data == $past(i_rx_data)
    && o_ext_last == $past(i_rx_last)) else $error("ext word not the input word");
  a_mic_ext_apart: assert property (!(o_mic_valid && o_ext_valid)) else $error("mic and ext together");
endmodule // acf_chk
bind acf_host_framer acf_chk u_chk
(
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last),
  .i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last),
  .o_rx_ready(o_rx_ready), .o_mic_valid(o_mic_valid), .o_mic_data(o_mic_data), .o_mic_last(o_mic_last),
  .o_ext_valid(o_ext_valid), .o_ext_data(o_ext_data), .o_ext_last(o_ext_last)
);
`default_nettype wire

// File: acf_client_model.sv
// Purpose: behavioural client at the far end of the unit links
// Assumes: one word per cycle, no back-pressure from the host on units sent to it
// Notes: ready stalls at random; idle rx data is scrambled
`timescale 1ns/1ns
`default_nettype none
module acf_client_model
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // units from the host
  input wire logic i_tx_valid,
  input wire logic [31:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  // units to the host
  output logic o_rx_valid,
  output logic [31:0] o_rx_data,
  output logic o_rx_last
);
  integer seed_m = 39;
  integer units = 0;
  logic [31:0] got_q[$];
  initial
  begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 32'h00000000;
    o_rx_last = 1'b0;
  end
  // takes any stereo pcm or mono dvi4 stream on its audio channel, mixing is not modelled
  always @(posedge i_clk)
  begin
    o_tx_ready <= !i_rst && ($random(seed_m) % 4 != 0);
    if (i_tx_valid && o_tx_ready)
    begin
      got_q.push_back(i_tx_data);
      if (i_tx_last)
        units <= units + 1;
    end
  end
  // one unit out, lines scrambled once released
  task automatic send(input logic [31:0] w[$]);
    integer k;
    for (k = 0; k < w.size(); k++)
    begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= w[k];
      o_rx_last <= (k == w.size() - 1);
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~w[w.size() - 1];
    o_rx_last <= 1'b0;
  endtask
endmodule // acf_client_model
`default_nettype wire

// File: acf_host_framer_tb_top.sv
// Purpose: self-checking bench for acf_host_framer
// Assumes: 25 MHz clock, apb master with bounded waits
// Notes: seed fixed at 39; pacing shortened to 50 cycles
`timescale 1ns/1ns
`default_nettype none
`include "acf_consts.vh"
module acf_host_framer_tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000, o_prdata, o_tx_data, i_rx_data, o_mic_data, o_ext_data;
  logic o_pready, o_pslverr, o_tx_valid, o_tx_last, i_tx_ready, i_rx_valid, i_rx_last, o_rx_ready;
  logic o_mic_valid, o_mic_last, o_ext_valid, o_ext_last, err;
  integer seed = 39, mismatches = 0, compares = 0, k, i, n, ts;
  logic [31:0] rd, l0, ch, tag;
  logic [31:0] mic_q[$], ext_q[$], pay[$];
  always #20 i_clk = ~i_clk;
  acf_host_framer #(.P_UNIT_CYCLES(24'd50)) dut
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready),
    .o_mic_valid(o_mic_valid), .o_mic_data(o_mic_data), .o_mic_last(o_mic_last),
    .o_ext_valid(o_ext_valid), .o_ext_data(o_ext_data), .o_ext_last(o_ext_last)
  );
  acf_client_model client
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_last(o_tx_last),
    .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_rx_last(i_rx_last)
  );
  always @(posedge i_clk)
  begin
    if (o_mic_valid === 1'b1)
      mic_q.push_back(o_mic_data);
    if (o_ext_valid === 1'b1)
      ext_q.push_back(o_ext_data);
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] cmd_word(input integer words);
    return {`ACF_CMD_OUT, `ACF_CMD_SUB, 16'(words * 4)};
  endfunction
  task automatic wait_units(input integer u);
    for (i = 0; i < 2000 && client.units < u; i++)
      @(posedge i_clk);
    if (i == 2000)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer c;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    c = 0;
    do
    begin
      @(posedge i_clk);
      c++;
    end
    while (o_pready !== 1'b1 && c < 50);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (c == 50)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  // kind 0 mic unit, 1 extended unit, 2 dropped unit
  task automatic rx_case(input logic [7:0] lead, input logic [7:0] cmd, input logic [15:0] sq, input integer kind);
    logic [31:0] w[$];
    logic [31:0] e[$];
    integer j;
    apb(1'b1, `ACF_REG_STAT, 32'h0000001F);
    mic_q.delete();
    ext_q.delete();
    w = '{{lead, 24'h00A5C3}, {cmd, 8'h01, 16'h0014}, {sq, 16'h0000}, $random(seed), $random(seed)};
    client.send(w);
    repeat (3) @(posedge i_clk);
    if (kind == 0)
      e = w[3:4];
    else
      e = w[1:4];
    chk("mic count", (kind == 0) ? 32'd2 : 32'd0, mic_q.size());
    chk("ext count", (kind == 1) ? 32'd4 : 32'd0, ext_q.size());
    for (j = 0; j < 2 * kind + 2 && kind < 2; j++)
      chk("pass word", e[j], (kind == 1) ? ext_q[j] : mic_q[j]);
    apb(1'b0, `ACF_REG_STAT, 32'h00000000);
    chk("stat event", 32'd1, rd[(kind == 0) ? 1 : (kind == 1) ? 4 : 3]);
  endtask
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b0, `ACF_REG_CODEC, 32'h00000000);
    chk("codec reset", `ACF_CODEC_RST, rd);
    apb(1'b0, 8'h3C, 32'h00000000);
    chk("unmapped err", 32'd1, err);
    rx_case(8'h00, `ACF_CMD_IN, 16'd5, 0);
    apb(1'b0, `ACF_REG_RXINFO, 32'h00000000);
    l0 = rd;
    rx_case(8'h00, `ACF_CMD_IN, 16'd8, 0);
    chk("gap flag", 32'd1, rd[2]);
    apb(1'b0, `ACF_REG_RXINFO, 32'h00000000);
    chk("lost count", {l0[31:16] + 16'd2, 16'd8}, rd);
    rx_case(8'h00, `ACF_CMD_OUT, 16'd9, 2);
    rx_case(($random(seed) & 8'hF3) | 8'h04, 8'h00, 16'd0, 1);
    rx_case(8'h0C, `ACF_CMD_IN, 16'd0, 2);
    for (k = 0; k < 4; k++)
    begin
      ts = k % 2;
      n = (k == 3) ? 20 : 1 + ({$random(seed)} % 4);
      ch = {8'h00, 24'($random(seed))};
      tag = $random(seed);
      pay.delete();
      apb(1'b1, `ACF_REG_CHAN, ch);
      apb(1'b1, `ACF_REG_TSTAG, tag);
      for (i = 0; i < n + k / 3; i++)
      begin
        pay.push_back($random(seed));
        apb(1'b1, `ACF_REG_DATA, pay[i]);
      end
      apb(1'b0, `ACF_REG_DATA, 32'h00000000);
      chk("data count", n, rd);
      if (k == 0)
      begin
        apb(1'b1, `ACF_REG_CTRL, 32'h00000001);
        repeat (20) @(posedge i_clk);
        chk("no early unit", 32'd0, client.got_q.size());
      end
      apb(1'b1, `ACF_REG_CTRL, 32'h00000005 | (ts << 1));
      wait_units(k + 1);
      chk("lead word", ch, client.got_q.pop_front());
      chk("cmd word", cmd_word(3 + ts + n), client.got_q.pop_front());
      if (ts == 1)
        chk("time tag", tag, client.got_q.pop_front());
      chk("seq word", {16'(k), 16'd8}, client.got_q.pop_front());
      for (i = 0; i < n; i++)
        chk("payload", pay[i], client.got_q.pop_front());
    end
    for (k = 0; k < 2; k++)
    begin
      apb(1'b1, `ACF_REG_CODEC, {8'(k), 8'h10, 8'h02, 8'h01});
      apb(1'b1, `ACF_REG_CTRL, 32'h0000000C);
      wait_units(5 + k);
      chk("record head", {`ACF_PRM_TYPE, `ACF_PRM_LEN}, client.got_q.pop_front());
      chk("record body", {8'(k), 8'h10, 8'h02, 8'h01}, client.got_q.pop_front());
    end
    // paced units, channel id frozen while pacing runs
    apb(1'b1, `ACF_REG_CTRL, 32'h00000014);
    apb(1'b1, `ACF_REG_CHAN, {8'h00, ~ch[23:0]});
    wait_units(8);
    chk("auto pace", 32'd1, i >= 100);
    chk("auto lead", ch, client.got_q.pop_front());
    chk("auto cmd", cmd_word(3), client.got_q.pop_front());
    chk("auto seq", {16'd4, 16'd8}, client.got_q.pop_front());
    apb(1'b0, `ACF_REG_CHAN, 32'h00000000);
    chk("chan frozen", ch, rd);
    stop_test();
  end
endmodule // acf_host_framer_tb_top
`default_nettype wire
